// ---- hdl/lfc_flash_ctrl.sv ----
// Mode sequencing, flash timer, fault flags and current selection of the flash driver
`timescale 1ns/1ps
`include "lfc_regs.svh"
// Functional notes
// - Select pin high picks serial slave, low picks the two-bit pin interface.
// - Overvoltage trip turns the LED off and latches a readable fault.
// - Assist light may go straight to flash by strobe or pins.
// - Torch and assist share one programmed current.
// - Pin code 00 torch/off, 01 assist, 10 reserved zero, 11 flash.
// - Pin code 00 uses torch pin: high torch, low shutdown.
// - Pin mode currents: 80/40 mA torch-assist, 500/320 mA flash.
// - Transmit mask in flash keeps flash but drops to assist current.
// - Slave answers write address 0x60 and read address 0x61.
// - Serial mode torch pin works only when torch is allowed.
// - Serial mode currents come from the current register.
// - Undervoltage lockout returns every register to default.
// - Subaddress byte after write address picks the first register.
// - Each complete written byte is acknowledged, except a foreign address byte and the bytes after it.
// - Write subaddress advances after each byte until stop.
// - Read returns selected register then successive ones until the master does not acknowledge.
// - Level-strobe flash ending by timer sets the timeout fault.
// - Output mode field: 00 standby, 10 assist, 11 flash, 01 reserved.
// - Serial mode flash time is 100 ms plus 50 ms per timer code step.
// - Mask enable bit; when off the mask input is ignored.
module lfc_flash_ctrl #(
   parameter int unsigned FLASH_BASE_CYC = `LFC_FLASH_BASE_MS * `LFC_CLK_KHZ,
   parameter int unsigned FLASH_STEP_CYC = `LFC_FLASH_STEP_MS * `LFC_CLK_KHZ
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic i2c_sel,
   input wire logic scl,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic torch,
   input wire logic strobe_in,
   output logic strobe_out,
   output logic strobe_oe,
   input wire logic tx_mask,
   input wire logic ovp_trip,
   input wire logic led_two,
   output logic led_en,
   output logic [9:0] led_ma,
   output lfc_pkg::lfc_state_t led_state,
   output lfc_pkg::lfc_flt_t status
);
   import lfc_pkg::*;

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   localparam int NPIN = 8;
   logic [NPIN-1:0] pin_raw;
   logic [NPIN-1:0] pin_s;
   logic sel_s, scl_s, sda_s, torch_s, stb_s, mask_s, ovp_s, two_s;

   assign pin_raw = {i2c_sel, scl, sda_in, torch, strobe_in, tx_mask, ovp_trip, led_two};
   assign {sel_s, scl_s, sda_s, torch_s, stb_s, mask_s, ovp_s, two_s} = pin_s;

   genvar gi;
   generate
      for (gi = 0; gi < NPIN; gi++) begin : g_sync
         logic m_q;
         logic s_q;
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               m_q <= 1'b0;
               s_q <= 1'b0;
            end else begin
               m_q <= pin_raw[gi];
               s_q <= m_q;
            end
         end
         assign pin_s[gi] = s_q;
      end
   endgenerate

   // ----------------------------------------------------------------
   // Start and stop detection for the serial link
   // ----------------------------------------------------------------
   logic sda_d1_q;
   logic frm_rst_q;
   logic arm_q;
   logic start_det;
   logic stop_det;

   assign start_det = scl_s && sda_d1_q && !sda_s;
   assign stop_det = scl_s && !sda_d1_q && sda_s;

   // A start pulses the link reset so a repeated start resyncs the byte engine;
   // the link is held idle while the pin interface is selected.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sda_d1_q <= 1'b1;
         frm_rst_q <= 1'b1;
         arm_q <= 1'b0;
      end else begin
         sda_d1_q <= sda_s;
         if (!sel_s || stop_det) begin
            frm_rst_q <= 1'b1;
            arm_q <= 1'b0;
         end else if (start_det) begin
            frm_rst_q <= 1'b1;
            arm_q <= 1'b1;
         end else if (arm_q) begin
            frm_rst_q <= 1'b0;
            arm_q <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Serial link and register write crossing
   // ----------------------------------------------------------------
   lfc_cfg_t lnk_cfg;
   logic [7:0] lnk_idx;
   logic lnk_tgl;
   logic link_oe;
   lfc_flt_t flt_q;

   lfc_i2c_link u_link (
      .scl(scl),
      .rst(rst),
      .frm_rst(frm_rst_q),
      .sda_in(sda_in),
      .sda_oe_q(link_oe),
      .flt(flt_q),
      .cfg_q(lnk_cfg),
      .wr_idx_q(lnk_idx),
      .wr_tgl_q(lnk_tgl)
   );

   assign sda_out = 1'b0;
   assign sda_oe = link_oe;

   logic tgl_m_q, tgl_s_q, tgl_d_q;
   logic wr_ev_q;
   logic [7:0] widx_q;
   lfc_cfg_t cfg_q;
   logic mode_wr;

   // The link holds its register copy steady for a whole byte after each
   // toggle, so the bus is copied once the toggle has settled here.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tgl_m_q <= 1'b0;
         tgl_s_q <= 1'b0;
         tgl_d_q <= 1'b0;
         wr_ev_q <= 1'b0;
         widx_q <= 8'h00;
         cfg_q <= {`LFC_TMR_RST, `LFC_CUR_RST, `LFC_MODE_RST, `LFC_INCTL_RST};
      end else begin
         tgl_m_q <= lnk_tgl;
         tgl_s_q <= tgl_m_q;
         tgl_d_q <= tgl_s_q;
         wr_ev_q <= tgl_s_q ^ tgl_d_q;
         if (tgl_s_q ^ tgl_d_q) begin
            cfg_q <= lnk_cfg;
            widx_q <= lnk_idx;
         end
      end
   end

   assign mode_wr = wr_ev_q && widx_q == `LFC_REG_MODE;

   // ----------------------------------------------------------------
   // Strobe qualification
   // ----------------------------------------------------------------
   logic stb_act;
   logic stb_d1_q;
   logic stb_en;
   logic lvl_mode;
   logic lvl_blk_q;
   logic by_lvl_q;
   logic sw_fl, lvl_fl, edg_fl, fl_stop;
   logic [1:0] om;

   assign om = cfg_q.mode[1:0];
   assign stb_act = stb_s ~^ cfg_q.inctl[`LFC_INCTL_POL];
   assign stb_en = cfg_q.mode[`LFC_MODE_STB_EN];
   assign lvl_mode = cfg_q.mode[`LFC_MODE_LEVEL];
   assign sw_fl = mode_wr && om == `LFC_OM_FLASH;
   assign lvl_fl = stb_en && lvl_mode && stb_act && !lvl_blk_q;
   assign edg_fl = stb_en && !lvl_mode && stb_act && !stb_d1_q;
   assign fl_stop = mode_wr && om != `LFC_OM_FLASH;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) stb_d1_q <= 1'b0;
      else stb_d1_q <= stb_act;
   end

   // ----------------------------------------------------------------
   // Flash timer
   // ----------------------------------------------------------------
   lfc_state_t st_q;
   logic [31:0] fl_cnt_q;
   logic [31:0] fl_lim;
   logic tmr_done;

   assign fl_lim = 32'(FLASH_BASE_CYC) + 32'(cfg_q.tmr[3:0]) * 32'(FLASH_STEP_CYC);
   assign tmr_done = sel_s && st_q == ST_FLASH && fl_cnt_q == fl_lim - 32'h1;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) fl_cnt_q <= 32'h0;
      else if (st_q != ST_FLASH || !sel_s) fl_cnt_q <= 32'h0;
      else fl_cnt_q <= fl_cnt_q + 32'h1;
   end

   // Level flash that timed out stays off until the strobe is released,
   // otherwise the still-active level would retrigger it at once.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         by_lvl_q <= 1'b0;
         lvl_blk_q <= 1'b0;
      end else begin
         if (st_q != ST_FLASH) by_lvl_q <= lvl_fl && !sw_fl && !edg_fl;
         if (tmr_done && by_lvl_q) lvl_blk_q <= 1'b1;
         else if (!stb_act || !lvl_mode) lvl_blk_q <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Mode state
   // ----------------------------------------------------------------
   function automatic lfc_state_t pin_mode(input logic b_one, input logic b_two, input logic trq);
      if (b_one && b_two) pin_mode = ST_FLASH;
      else if (b_one) pin_mode = ST_RSVD;
      else if (b_two) pin_mode = ST_ASSIST;
      else if (trq) pin_mode = ST_TORCH;
      else pin_mode = ST_SHUT;
   endfunction

   lfc_state_t base_st;
   logic lvl_end;

   always_comb begin
      if (om == `LFC_OM_ASSIST) base_st = ST_ASSIST;
      else if (cfg_q.mode[`LFC_MODE_TORCH_OK] && torch_s) base_st = ST_TORCH;
      else base_st = ST_SHUT;
   end

   assign lvl_end = by_lvl_q && !stb_act;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_q <= ST_SHUT;
      end else if (!sel_s) begin
         st_q <= pin_mode(scl_s, sda_s, torch_s);
      end else begin
         case (st_q)
            ST_FLASH: begin
               if (tmr_done || lvl_end || fl_stop) st_q <= base_st;
            end
            default: begin
               if (sw_fl || lvl_fl || edg_fl) st_q <= ST_FLASH;
               else st_q <= base_st;
            end
         endcase
      end
   end

   assign led_state = st_q;

   // ----------------------------------------------------------------
   // Fault flags
   // ----------------------------------------------------------------
   logic flt_clr;

   // Faults are cleared by a mode write, or by pin shutdown; a new trip wins.
   assign flt_clr = sel_s ? mode_wr : (st_q == ST_SHUT);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         flt_q <= '0;
      end else begin
         if (ovp_s) flt_q.ovp <= 1'b1;
         else if (flt_clr) flt_q.ovp <= 1'b0;
         if (tmr_done && by_lvl_q) flt_q.tmo <= 1'b1;
         else if (flt_clr) flt_q.tmo <= 1'b0;
         flt_q.two <= two_s;
      end
   end

   assign status = flt_q;

   // ----------------------------------------------------------------
   // LED current selection
   // ----------------------------------------------------------------
   logic [9:0] ta_ma;
   logic [9:0] fl_ma;
   logic [9:0] cur_ma;
   logic mask_on;

   always_comb begin
      if (sel_s) begin
         ta_ma = `LFC_I_TA_BASE + 10'(cfg_q.cur[2:0]) * `LFC_I_STEP;
         fl_ma = `LFC_I_FL_BASE + 10'(cfg_q.cur[7:4]) * `LFC_I_STEP;
      end else begin
         ta_ma = two_s ? `LFC_I_TA_TWO : `LFC_I_TA_ONE;
         fl_ma = two_s ? `LFC_I_FL_TWO : `LFC_I_FL_ONE;
      end
   end

   assign mask_on = cfg_q.inctl[`LFC_INCTL_MASK_OK] && mask_s;

   always_comb begin
      case (st_q)
         ST_TORCH: cur_ma = ta_ma;
         ST_ASSIST: cur_ma = ta_ma;
         ST_FLASH: cur_ma = mask_on ? ta_ma : fl_ma;
         default: cur_ma = 10'h000;
      endcase
   end

   logic led_en_q;
   logic [9:0] led_ma_q;
   logic strobe_out_q;
   logic strobe_oe_q;

   // An overvoltage fault holds the driver off until the fault is cleared.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         led_en_q <= 1'b0;
         led_ma_q <= 10'h000;
      end else if (flt_q.ovp || ovp_s) begin
         led_en_q <= 1'b0;
         led_ma_q <= 10'h000;
      end else begin
         led_en_q <= cur_ma != 10'h000;
         led_ma_q <= cur_ma;
      end
   end

   // In pin mode the strobe pin reports the detected LED count.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         strobe_out_q <= 1'b0;
         strobe_oe_q <= 1'b0;
      end else begin
         strobe_out_q <= two_s;
         strobe_oe_q <= !sel_s;
      end
   end

   assign led_en = led_en_q;
   assign led_ma = led_ma_q;
   assign strobe_out = strobe_out_q;
   assign strobe_oe = strobe_oe_q;
endmodule

// ---- include/lfc_regs.svh ----
// Register offsets, field positions, reset values and timing of the flash controller
`ifndef LFC_REGS_SVH
`define LFC_REGS_SVH
`define LFC_I2C_WR_ADDR 8'h60
`define LFC_I2C_RD_ADDR 8'h61
`define LFC_REG_ID 8'h00
`define LFC_REG_VER 8'h01
`define LFC_REG_TMR 8'h02
`define LFC_REG_CUR 8'h03
`define LFC_REG_MODE 8'h04
`define LFC_REG_FAULT 8'h05
`define LFC_REG_INCTL 8'h06
`define LFC_TMR_RST 8'h0F
`define LFC_CUR_RST 8'h61
`define LFC_MODE_RST 8'hB4
`define LFC_INCTL_RST 8'h06
`define LFC_INCTL_WMASK 8'h07
`define LFC_OM_ASSIST 2'h2
`define LFC_OM_FLASH 2'h3
`define LFC_MODE_STB_EN 2
`define LFC_MODE_TORCH_OK 4
`define LFC_MODE_LEVEL 5
`define LFC_INCTL_MASK_OK 1
`define LFC_INCTL_POL 2
`define LFC_FLT_OVP 7
`define LFC_FLT_TMO 4
`define LFC_FLT_TWO 3
`define LFC_I_TA_ONE 10'h050
`define LFC_I_TA_TWO 10'h028
`define LFC_I_FL_ONE 10'h1F4
`define LFC_I_FL_TWO 10'h140
`define LFC_I_TA_BASE 10'h014
`define LFC_I_FL_BASE 10'h0C8
`define LFC_I_STEP 10'h014
`define LFC_CLK_KHZ 40000
`define LFC_FLASH_BASE_MS 100
`define LFC_FLASH_STEP_MS 50
`endif

// ---- include/lfc_pkg.sv ----
// Shared types of the LED flash mode controller
package lfc_pkg;
   typedef enum logic [2:0] {
      ST_SHUT = 3'b000,
      ST_TORCH = 3'b001,
      ST_ASSIST = 3'b010,
      ST_FLASH = 3'b011,
      ST_RSVD = 3'b100
   } lfc_state_t;
   typedef enum logic [2:0] {
      LS_ADDR = 3'b000,
      LS_SUB = 3'b001,
      LS_WDATA = 3'b010,
      LS_RDATA = 3'b011,
      LS_IGNORE = 3'b100
   } lfc_lst_t;
   typedef struct packed {
      logic [7:0] tmr;
      logic [7:0] cur;
      logic [7:0] mode;
      logic [7:0] inctl;
   } lfc_cfg_t;
   typedef struct packed {
      logic ovp;
      logic tmo;
      logic two;
   } lfc_flt_t;
endpackage

// ---- hdl/lfc_i2c_link.sv ----
// Serial slave byte engine and writable registers, clocked by the serial clock pin
`timescale 1ns/1ps
`include "lfc_regs.svh"
module lfc_i2c_link #(
   parameter logic [7:0] ID_CODE = 8'h5A,
   parameter logic [7:0] VER_CODE = 8'h03
) (
   input wire logic scl,
   input wire logic rst,
   input wire logic frm_rst,
   input wire logic sda_in,
   output logic sda_oe_q,
   input wire lfc_pkg::lfc_flt_t flt,
   output lfc_pkg::lfc_cfg_t cfg_q,
   output logic [7:0] wr_idx_q,
   output logic wr_tgl_q
);
   import lfc_pkg::*;
   lfc_lst_t st_q;
   logic [3:0] cnt_q;
   logic [7:0] sr_q, tx_q, sub_q, byte_in;
   logic ack_q;
   lfc_flt_t flt_m_q, flt_s_q;

   assign byte_in = {sr_q[6:0], sda_in};

   function automatic logic [7:0] rd_reg(input logic [7:0] idx);
      logic [7:0] f;
      f = 8'h00;
      f[`LFC_FLT_OVP] = flt_s_q.ovp;
      f[`LFC_FLT_TMO] = flt_s_q.tmo;
      f[`LFC_FLT_TWO] = flt_s_q.two;
      if (idx == `LFC_REG_ID) rd_reg = ID_CODE; // Arbitrary identity value
      else if (idx == `LFC_REG_VER) rd_reg = VER_CODE; // Arbitrary identity value
      else if (idx == `LFC_REG_TMR) rd_reg = cfg_q.tmr;
      else if (idx == `LFC_REG_CUR) rd_reg = cfg_q.cur;
      else if (idx == `LFC_REG_MODE) rd_reg = cfg_q.mode;
      else if (idx == `LFC_REG_FAULT) rd_reg = f;
      else if (idx == `LFC_REG_INCTL) rd_reg = cfg_q.inctl;
      else rd_reg = 8'h00;
   endfunction

   // Frame state; held in reset between stop and start
   always_ff @(posedge scl or posedge frm_rst) begin
      if (frm_rst) begin
         st_q <= LS_ADDR;
         cnt_q <= 4'h0;
         sr_q <= 8'h00;
         ack_q <= 1'b0;
      end else if (cnt_q != 4'h8) begin
         sr_q <= byte_in;
         cnt_q <= cnt_q + 4'h1;
         if (cnt_q == 4'h7) begin
            ack_q <= (st_q == LS_SUB) || (st_q == LS_WDATA) ||
               (st_q == LS_ADDR && (byte_in == `LFC_I2C_WR_ADDR ||
               byte_in == `LFC_I2C_RD_ADDR));
         end
      end else begin
         cnt_q <= 4'h0;
         ack_q <= 1'b0;
         case (st_q)
            LS_ADDR: begin
               if (sr_q == `LFC_I2C_WR_ADDR) st_q <= LS_SUB;
               else if (sr_q == `LFC_I2C_RD_ADDR) st_q <= LS_RDATA;
               else st_q <= LS_IGNORE;
            end
            LS_SUB: st_q <= LS_WDATA;
            LS_RDATA: st_q <= sda_in ? LS_IGNORE : LS_RDATA;
            default: st_q <= st_q;
         endcase
      end
   end

   // Registers survive repeated starts; only the lockout reset clears them
   always_ff @(posedge scl or posedge rst) begin
      if (rst) begin
         sub_q <= 8'h00;
         tx_q <= 8'h00;
         wr_idx_q <= 8'h00;
         wr_tgl_q <= 1'b0;
         cfg_q <= {`LFC_TMR_RST, `LFC_CUR_RST, `LFC_MODE_RST, `LFC_INCTL_RST};
      end else if (cnt_q == 4'h8) begin
         if (st_q == LS_SUB) begin
            sub_q <= sr_q;
         end else if (st_q == LS_WDATA) begin
            if (sub_q == `LFC_REG_TMR) cfg_q.tmr <= sr_q;
            else if (sub_q == `LFC_REG_CUR) cfg_q.cur <= sr_q;
            else if (sub_q == `LFC_REG_MODE) cfg_q.mode <= sr_q;
            else if (sub_q == `LFC_REG_INCTL) cfg_q.inctl <= sr_q & `LFC_INCTL_WMASK;
            wr_idx_q <= sub_q;
            wr_tgl_q <= ~wr_tgl_q;
            sub_q <= sub_q + 8'h01;
         end else if ((st_q == LS_ADDR && sr_q == `LFC_I2C_RD_ADDR) ||
               (st_q == LS_RDATA && !sda_in)) begin
            tx_q <= rd_reg(sub_q);
            sub_q <= sub_q + 8'h01;
         end
      end else if (st_q == LS_RDATA) begin
         tx_q <= {tx_q[6:0], 1'b0};
      end
   end

   always_ff @(posedge scl or posedge rst) begin
      if (rst) begin
         flt_m_q <= '0;
         flt_s_q <= '0;
      end else begin
         flt_m_q <= flt;
         flt_s_q <= flt_m_q;
      end
   end

   // Data and acknowledge change only while the serial clock is low
   always_ff @(negedge scl or posedge frm_rst) begin
      if (frm_rst) sda_oe_q <= 1'b0;
      else sda_oe_q <= (cnt_q == 4'h8 && ack_q) ||
         (st_q == LS_RDATA && cnt_q != 4'h8 && !tx_q[7]);
   end
endmodule

// ---- sim/lfc_flash_ctrl_asserts.sv ----
// Port-level checks of the flash mode controller
`timescale 1ns/1ps
`include "lfc_regs.svh"
module lfc_flash_ctrl_asserts #(
   parameter int unsigned FLASH_BASE_CYC = 40,
   parameter int unsigned FLASH_STEP_CYC = 20
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic i2c_sel,
   input wire logic scl,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe,
   input wire logic torch,
   input wire logic strobe_in,
   input wire logic strobe_out,
   input wire logic strobe_oe,
   input wire logic tx_mask,
   input wire logic ovp_trip,
   input wire logic led_two,
   input wire logic led_en,
   input wire logic [9:0] led_ma,
   input wire lfc_pkg::lfc_state_t led_state,
   input wire lfc_pkg::lfc_flt_t status
);
   import lfc_pkg::*;
   // Longest timed flash plus entry slack
   localparam int unsigned FLASH_MAX = FLASH_BASE_CYC + 15 * FLASH_STEP_CYC + 4;
   logic [9:0] ta_ma;
   logic [9:0] fl_ma;
   logic [31:0] fl_cnt_q;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   assign ta_ma = led_two ? `LFC_I_TA_TWO : `LFC_I_TA_ONE;
   assign fl_ma = led_two ? `LFC_I_FL_TWO : `LFC_I_FL_ONE;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         fl_cnt_q <= '0;
      end else if (i2c_sel && led_state == ST_FLASH) begin
         fl_cnt_q <= fl_cnt_q + 32'h1;
      end else begin
         fl_cnt_q <= '0;
      end
   end
   // Pins held long enough to pass the synchronisers and the output register
   sequence pin_hold(b1, b2);
      (!i2c_sel && scl == b1 && sda_in == b2 && !ovp_trip && $stable(led_two)
         && $stable(torch) && $stable(tx_mask))[*6];
   endsequence
   pin_flash_a: assert property (
      pin_hold(1'b1, 1'b1) ##0 !tx_mask |-> led_en && led_state == ST_FLASH && led_ma == fl_ma)
      else $error("pin flash state or current wrong");
   pin_assist_a: assert property (
      pin_hold(1'b0, 1'b1) |-> led_state == ST_ASSIST && led_ma == ta_ma)
      else $error("pin assist state or current wrong");
   pin_rsvd_a: assert property (
      pin_hold(1'b1, 1'b0) |-> led_state == ST_RSVD && !led_en && led_ma == 10'h000)
      else $error("reserved pin code drives current");
   pin_torch_a: assert property (
      pin_hold(1'b0, 1'b0) |-> led_state == (torch ? ST_TORCH : ST_SHUT))
      else $error("torch pin decode wrong");
   mask_cut_a: assert property (
      pin_hold(1'b1, 1'b1) ##0 tx_mask |-> led_state == ST_FLASH && led_ma == ta_ma)
      else $error("masked flash current wrong");
   pin_strobe_a: assert property (
      (!i2c_sel && $stable(led_two))[*4] |-> strobe_oe && strobe_out == led_two && !sda_oe)
      else $error("pin mode strobe or data line wrong");
   ser_strobe_a: assert property (
      i2c_sel[*4] |-> !strobe_oe)
      else $error("strobe driven in serial mode");
   ovp_off_a: assert property (
      ovp_trip[*4] |-> !led_en && status.ovp)
      else $error("overvoltage did not stop driver");
   flash_len_a: assert property (
      fl_cnt_q <= FLASH_MAX)
      else $error("flash outlasts timer");
endmodule
bind lfc_flash_ctrl lfc_flash_ctrl_asserts #(.FLASH_BASE_CYC(FLASH_BASE_CYC),
   .FLASH_STEP_CYC(FLASH_STEP_CYC)) u_chk (.clk(clk), .rst(rst), .i2c_sel(i2c_sel),
   .scl(scl), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .torch(torch),
   .strobe_in(strobe_in), .strobe_out(strobe_out), .strobe_oe(strobe_oe),
   .tx_mask(tx_mask), .ovp_trip(ovp_trip), .led_two(led_two), .led_en(led_en),
   .led_ma(led_ma), .led_state(led_state), .status(status));

// ---- sim/lfc_host.sv ----
// Host processor model: serial master and mode pin driver on the shared lines
`timescale 1ns/1ps
`include "lfc_regs.svh"
module lfc_host (
   output logic scl,
   output logic sda_low,
   input wire logic sda
);
   // Clock stands high between frames, data line left to the pull-up
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   task automatic set_pins(input logic b1, input logic b2);
      scl = b1;
      sda_low = ~b2;
   endtask
   // ----
   // Bit level, data moved mid-way through the low phase, except the start and stop edges made while the clock is high
   // ----
   task automatic start();
      if (scl === 1'b0) begin
         #37.5 sda_low = 1'b0;
         #37.5 scl = 1'b1;
      end
      #160 sda_low = 1'b1;
      #160 scl = 1'b0;
   endtask
   task automatic stop();
      #37.5 sda_low = 1'b1;
      #37.5 scl = 1'b1;
      #160 sda_low = 1'b0;
      #160;
   endtask
   task automatic put(input logic b);
      #37.5 sda_low = ~b;
      #37.5 scl = 1'b1;
      #50 scl = 1'b0;
   endtask
   task automatic get(output logic b);
      #37.5 sda_low = 1'b0;
      #37.5 scl = 1'b1;
      b = sda;
      #50 scl = 1'b0;
   endtask
   task automatic wr(input logic [7:0] v, output logic ack);
      logic b;
      for (int i = 7; i >= 0; i--) put(v[i]);
      get(b);
      ack = ~b;
   endtask
   task automatic rd(input logic more, output logic [7:0] v);
      for (int i = 7; i >= 0; i--) get(v[i]);
      put(~more);
   endtask
   task automatic wframe(input logic [7:0] sub, input logic [7:0] d [4], input int n,
      output int nak);
      logic a;
      nak = 0;
      start();
      wr(`LFC_I2C_WR_ADDR, a);
      nak += int'(!a);
      wr(sub, a);
      nak += int'(!a);
      for (int i = 0; i < n; i++) begin
         wr(d[i], a);
         nak += int'(!a);
      end
      stop();
   endtask
   task automatic rframe(input logic [7:0] sub, input int n, output logic [7:0] q [4]);
      logic a;
      start();
      wr(`LFC_I2C_WR_ADDR, a);
      wr(sub, a);
      start();
      wr(`LFC_I2C_RD_ADDR, a);
      for (int i = 0; i < n; i++) begin
         rd(i < n - 1, q[i]);
      end
      stop();
   endtask
endmodule

// ---- sim/tb.sv ----
// Self-checking bench of the flash mode controller
`timescale 1ns/1ps
`include "lfc_regs.svh"
module tb;
   import lfc_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic i2c_sel = 1'b0;
   logic torch = 1'b0;
   logic strobe_drv = 1'b0;
   logic tx_mask = 1'b0;
   logic ovp_trip = 1'b0;
   logic led_two = 1'b0;
   logic scl, host_low, sda, sda_out, sda_oe, strobe, strobe_out, strobe_oe, led_en;
   logic [9:0] led_ma;
   lfc_state_t led_state;
   lfc_flt_t status;
   logic [7:0] q [4];
   logic [7:0] d [4];
   int n_errors = 0;
   int comparisons = 0;
   int cyc = 0;
   int nak;
   assign sda = !(host_low || (sda_oe && !sda_out));
   assign strobe = strobe_oe ? strobe_out : strobe_drv;
   always #12.5 clk = ~clk;
   lfc_host host (.scl(scl), .sda_low(host_low), .sda(sda));
   lfc_flash_ctrl #(.FLASH_BASE_CYC(40), .FLASH_STEP_CYC(20)) DUT (.clk(clk), .rst(rst),
      .i2c_sel(i2c_sel), .scl(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
      .torch(torch), .strobe_in(strobe), .strobe_out(strobe_out), .strobe_oe(strobe_oe),
      .tx_mask(tx_mask), .ovp_trip(ovp_trip), .led_two(led_two), .led_en(led_en),
      .led_ma(led_ma), .led_state(led_state), .status(status));
   // ----
   // Helpers
   // ----
   task automatic cycles(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic chk(input string nm, input logic [9:0] e, input logic [9:0] g);
      comparisons++;
      if (g !== e) begin
         n_errors++;
         $display("[ERR] %s expected %0h seen %0h", nm, e, g);
      end
   endtask
   task automatic chk_st(input lfc_state_t e);
      comparisons++;
      if (led_state !== e) begin
         n_errors++;
         $display("[ERR] led_state expected %0d seen %0d", e, led_state);
      end
   endtask
   task automatic w1(input logic [7:0] sub, input logic [7:0] v);
      d[0] = v;
      host.wframe(sub, d, 1, nak);
      chk("ack", 10'h000, 10'(nak));
      cycles(4);
   endtask
   task automatic final_report();
      $display("comparisons %0d n_errors %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // ----
   // Scenarios
   // ----
   task automatic t_pins();
      lfc_state_t est [6];
      logic [9:0] ta, fl;
      est = '{ST_SHUT, ST_TORCH, ST_ASSIST, ST_FLASH, ST_FLASH, ST_RSVD};
      for (int t = 0; t < 2; t++) begin
         led_two = t[0];
         ta = t ? `LFC_I_TA_TWO : `LFC_I_TA_ONE;
         fl = t ? `LFC_I_FL_TWO : `LFC_I_FL_ONE;
         for (int k = 0; k < 6; k++) begin
            host.set_pins(k >= 3, k >= 2 && k != 5);
            torch = (k == 1);
            tx_mask = (k == 4);
            cycles(7);
            chk_st(est[k]);
            chk("led_ma", (k == 3) ? fl : (k == 0 || k == 5) ? 10'h000 : ta, led_ma);
            chk("strobe", 10'(t), 10'(strobe));
         end
      end
      torch = 1'b0;
      tx_mask = 1'b0;
   endtask
   task automatic t_wr_rd();
      logic a;
      i2c_sel = 1'b1;
      host.set_pins(1'b1, 1'b1);
      cycles(8);
      d[0] = 8'hA5;
      d[1] = 8'hB6;
      host.wframe(8'h03, d, 2, nak);
      chk("ack", 10'h000, 10'(nak));
      cycles(4);
      chk_st(ST_ASSIST);
      chk("led_ma", 10'h078, led_ma);
      host.rframe(8'h03, 2, q);
      chk("rd0", 10'h0A5, 10'(q[0]));
      chk("rd1", 10'h0B6, 10'(q[1]));
      host.start();
      host.wr(8'h62, a);
      host.stop();
      chk("foreign ack", 10'h000, 10'(a));
   endtask
   task automatic t_flash();
      w1(8'h02, 8'h00);
      w1(8'h04, 8'hB7);
      chk_st(ST_FLASH);
      chk("led_ma", 10'h190, led_ma);
      tx_mask = 1'b1;
      cycles(5);
      chk("led_ma", 10'h078, led_ma);
      cycles(40);
      chk("flash on", 10'h000, 10'(led_state == ST_FLASH));
      chk("tmo", 10'h000, 10'(status.tmo));
      w1(8'h06, 8'h04);
      w1(8'h04, 8'hB7);
      chk("led_ma", 10'h190, led_ma);
      tx_mask = 1'b0;
      w1(8'h04, 8'hB4);
   endtask
   task automatic t_strobe();
      strobe_drv = 1'b1;
      cycles(35);
      chk_st(ST_FLASH);
      cycles(20);
      chk("flash on", 10'h000, 10'(led_state == ST_FLASH));
      chk("tmo", 10'h001, 10'(status.tmo));
      strobe_drv = 1'b0;
      torch = 1'b1;
      w1(8'h04, 8'hB4);
      chk_st(ST_TORCH);
      chk("led_ma", 10'h078, led_ma);
      w1(8'h04, 8'hA4);
      chk_st(ST_SHUT);
      torch = 1'b0;
   endtask
   task automatic t_ovp();
      w1(8'h04, 8'hB6);
      ovp_trip = 1'b1;
      cycles(6);
      chk("led_en", 10'h000, 10'(led_en));
      chk("ovp", 10'h001, 10'(status.ovp));
      ovp_trip = 1'b0;
      host.rframe(8'h05, 1, q);
      chk("fault reg", 10'h001, 10'(q[0][7]));
      rst = 1'b1;
      cycles(3);
      rst = 1'b0;
      cycles(6);
      chk("status", 10'(led_two), 10'(status));
      host.rframe(8'h02, 3, q);
      chk("tmr", 10'(`LFC_TMR_RST), 10'(q[0]));
      chk("cur", 10'(`LFC_CUR_RST), 10'(q[1]));
      chk("mode", 10'(`LFC_MODE_RST), 10'(q[2]));
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         n_errors++;
         final_report();
      end
   end
   initial begin
      cycles(12);
      rst = 1'b0;
      t_pins();
      t_wr_rd();
      t_flash();
      t_strobe();
      t_ovp();
      final_report();
   end
endmodule
